// >>> common/vbs_defines.svh
`ifndef VBS_DEFINES_SVH
`define VBS_DEFINES_SVH
// Address modifier codes this slave answers (defaults of the top parameters)
`define VBS_AM_A32_DATA 6'h09
`define VBS_AM_A24_DATA 6'h39
`define VBS_AM_A16_DATA 6'h29
// Default slave window: address bits 31..16 compared
`define VBS_BASE_DEFAULT 16'h0000
// Default bus request level
`define VBS_REQ_LEVEL_DEFAULT 2'h3
// Default interrupt level, 3 bits
`define VBS_IRQ_LEVEL_DEFAULT 3'h1
`endif

// >>> common/vbs_pkg.sv
package vbs_pkg;
    // Strobes as seen on the bus, true means asserted; write_n and lword_n keep the pin level
    typedef struct packed {
        logic as;
        logic ds0;
        logic ds1;
        logic write_n;
        logic lword_n;
        logic iack;
    } vbs_strobe_s;

    typedef enum logic [1:0] {
        VBS_IDLE = 2'b00,
        VBS_WAIT = 2'b01,
        VBS_RESP = 2'b10,
        VBS_DONE = 2'b11
    } vbs_slave_e;

    typedef enum logic [1:0] {
        VBS_ARB_IDLE = 2'b00,
        VBS_ARB_REQ = 2'b01,
        VBS_ARB_OWN = 2'b10
    } vbs_arb_e;
endpackage : vbs_pkg

// >>> rtl/vbs_backplane.sv
`timescale 1ns/1ps
`include "vbs_defines.svh"
// Operation
// - Data lines three-state; driver holds valid data while data strobes asserted.
// - Master encodes transfer in address modifiers; slave decodes them to answer.
// - Addressed slave asserts transfer acknowledge when the transfer completes well.
// - Bus clear asks owner to release; a master may ignore it.
// - Handshake never paced by the system clock line, only strobes and acknowledge.
// - Requester receiving its grant blocks grant out, asserts busy, takes bus.
// - Pending interrupt at acknowledged level blocks acknowledge chain, drives status.
// - Interrupter returns status at requested width, else signals bus error.
module vbs_backplane
    import vbs_pkg::*;
#(
    parameter logic [5:0] AM_A32 = `VBS_AM_A32_DATA,
    parameter logic [5:0] AM_A24 = `VBS_AM_A24_DATA,
    parameter logic [5:0] AM_A16 = `VBS_AM_A16_DATA,
    parameter logic [15:0] BASE = `VBS_BASE_DEFAULT,
    parameter logic [1:0] REQ_LEVEL = `VBS_REQ_LEVEL_DEFAULT,
    parameter logic [2:0] IRQ_LEVEL = `VBS_IRQ_LEVEL_DEFAULT
) (
    // Clock, reset, enable
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_ce,
    // Bus strobes (active low pins) and address
    input wire logic i_as_n,
    input wire logic i_ds0_n,
    input wire logic i_ds1_n,
    input wire logic i_write_n,
    input wire logic i_lword_n,
    input wire logic i_iack_n,
    input wire logic [5:0] i_am,
    input wire logic [31:1] i_addr,
    // Data lines
    input wire logic [31:0] i_data,
    output logic [31:0] o_data,
    output logic o_data_oe,
    // Slave response, open drain
    output logic o_dtack_oe,
    output logic o_berr_oe,
    // Arbitration
    input wire logic i_bg_in_n,
    output logic o_bg_out_n,
    input wire logic i_bbsy_n,
    input wire logic i_bclr_n,
    output logic o_br_oe,
    output logic [1:0] o_br_level,
    output logic o_bbsy_oe,
    // Interrupt chain
    input wire logic i_iackin_n,
    output logic o_iackout_n,
    output logic o_irq_oe,
    // User side
    input wire logic i_want_bus,
    input wire logic i_release,
    output logic o_own_bus,
    output logic o_bclr_seen,
    input wire logic i_irq_req,
    input wire logic [31:0] i_status,
    input wire logic [1:0] i_status_width,
    input wire logic [31:0] i_rd_data,
    output logic o_wr_stb,
    output logic [31:0] o_wr_data,
    output logic [31:1] o_wr_addr
);
    // Two-stage synchronisers for every asynchronous pin
    localparam int SW = 6 + 6 + 31 + 32 + 4;
    logic [SW-1:0] sync1;
    logic [SW-1:0] sync2;
    logic [SW-1:0] pins;
    assign pins = {~i_as_n, ~i_ds0_n, ~i_ds1_n, i_write_n, i_lword_n, ~i_iack_n,
                   i_am, i_addr, i_data, ~i_bg_in_n, ~i_bbsy_n, ~i_bclr_n, ~i_iackin_n};
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            sync1 <= '0;
            sync2 <= '0;
        end else if (i_ce) begin
            sync1 <= pins;
            sync2 <= sync1;
        end
    end

    vbs_strobe_s st;
    logic [5:0] am;
    logic [31:1] addr;
    logic [31:0] wdata;
    logic bg_in;
    logic bbsy;
    logic bclr;
    logic iackin;
    assign {st, am, addr, wdata, bg_in, bbsy, bclr, iackin} = sync2;

    // Slave decode: address only looked at while address strobe asserted
    // strobe qualified decode
    logic am_hit;
    logic sel;
    logic ds_any;
    always_comb begin
        am_hit = (am == AM_A32) || (am == AM_A24) || (am == AM_A16);
        sel = st.as && !st.iack && am_hit && (addr[31:16] == BASE);
        ds_any = st.ds0 || st.ds1;
    end

    // Interrupt acknowledge match and width check
    logic irq_pend;
    logic iack_match;
    logic width_ok;
    logic [1:0] req_width;
    always_comb begin
        req_width = !st.lword_n ? 2'h2 : ((st.ds0 && st.ds1) ? 2'h1 : 2'h0);
        iack_match = st.as && st.iack && iackin && irq_pend && (addr[3:1] == IRQ_LEVEL);
        width_ok = (i_status_width >= req_width);
    end

    // Slave handshake state; paced by strobes only, clock merely samples them
    vbs_slave_e state;
    vbs_slave_e next_state;
    logic [31:0] next_data;
    logic next_oe;
    logic next_dtack;
    logic next_berr;
    logic next_wr;
    logic next_blocked;
    logic blocked;
    always_comb begin
        next_state = state;
        next_data = o_data;
        next_oe = o_data_oe;
        next_dtack = o_dtack_oe;
        next_berr = o_berr_oe;
        next_wr = 1'b0;
        next_blocked = blocked;
        case (state)
            VBS_IDLE: begin
                if (iack_match) begin
                    next_blocked = 1'b1;
                    next_state = VBS_WAIT;
                end else if (sel) begin
                    next_state = VBS_WAIT;
                end
            end
            VBS_WAIT: begin
                // wait for data strobes, no fixed timing
                if (!st.as) begin
                    next_state = VBS_IDLE;
                    next_blocked = 1'b0;
                end else if (ds_any) begin
                    next_state = VBS_RESP;
                    if (blocked) begin
                        if (width_ok) begin
                            next_data = i_status;
                            next_oe = 1'b1;
                            next_dtack = 1'b1;
                        end else begin
                            next_berr = 1'b1;
                        end
                    end else if (!st.write_n) begin
                        next_wr = 1'b1;
                        next_dtack = 1'b1;
                    end else begin
                        next_data = i_rd_data;
                        next_oe = 1'b1;
                        next_dtack = 1'b1;
                    end
                end
            end
            VBS_RESP: begin
                if (!ds_any) begin
                    next_oe = 1'b0;
                    next_dtack = 1'b0;
                    next_berr = 1'b0;
                    next_state = VBS_DONE;
                end
            end
            VBS_DONE: begin
                if (!st.as) begin
                    next_state = VBS_IDLE;
                    next_blocked = 1'b0;
                end
            end
            default: next_state = VBS_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            state <= VBS_IDLE;
            o_data <= 32'h0000_0000;
            o_data_oe <= 1'b0;
            o_dtack_oe <= 1'b0;
            o_berr_oe <= 1'b0;
            o_wr_stb <= 1'b0;
            blocked <= 1'b0;
        end else if (i_ce) begin
            state <= next_state;
            o_data <= next_data;
            o_data_oe <= next_oe;
            o_dtack_oe <= next_dtack;
            o_berr_oe <= next_berr;
            o_wr_stb <= next_wr;
            blocked <= next_blocked;
        end
    end

    // Write capture registers
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_wr_data <= 32'h0000_0000;
            o_wr_addr <= '0;
        end else if (i_ce && next_wr) begin
            o_wr_data <= wdata;
            o_wr_addr <= addr;
        end
    end

    // Interrupt pending: release on acknowledge; new request wins over the clear
    logic next_irq;
    always_comb begin
        next_irq = irq_pend;
        if (state == VBS_WAIT && blocked && ds_any && width_ok) begin
            next_irq = 1'b0;
        end
        if (i_irq_req) begin
            next_irq = 1'b1;
        end
    end
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            irq_pend <= 1'b0;
        end else if (i_ce) begin
            irq_pend <= next_irq;
        end
    end
    assign o_irq_oe = irq_pend;
    assign o_iackout_n = !(iackin && !blocked && !iack_match);

    // Requester: grant held locally while requesting or owning, passed on when idle
    vbs_arb_e arb;
    vbs_arb_e next_arb;
    always_comb begin
        next_arb = arb;
        case (arb)
            VBS_ARB_IDLE: begin
                if (i_want_bus) begin
                    next_arb = VBS_ARB_REQ;
                end
            end
            VBS_ARB_REQ: begin
                if (bg_in && !bbsy) begin
                    next_arb = VBS_ARB_OWN;
                end
            end
            VBS_ARB_OWN: begin
                // bus clear is only a hint
                if (i_release) begin
                    next_arb = VBS_ARB_IDLE;
                end
            end
            default: next_arb = VBS_ARB_IDLE;
        endcase
    end
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            arb <= VBS_ARB_IDLE;
        end else if (i_ce) begin
            arb <= next_arb;
        end
    end
    assign o_br_oe = (arb == VBS_ARB_REQ);
    assign o_br_level = REQ_LEVEL;
    assign o_bbsy_oe = (arb == VBS_ARB_OWN);
    assign o_own_bus = (arb == VBS_ARB_OWN);
    assign o_bclr_seen = bclr;
    // block grant while requesting or owning
    assign o_bg_out_n = !(bg_in && arb == VBS_ARB_IDLE);

    // Checks
    a_ack_needs_sel: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        $rose(o_dtack_oe) |-> $past(st.as)) else $error("ack without strobe");
    a_release_after_ds: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (o_dtack_oe && !ds_any && i_ce && state == VBS_RESP) |=> !o_dtack_oe)
        else $error("ack not released");
    a_data_with_ack: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (o_dtack_oe && st.write_n) |-> o_data_oe) else $error("no data on read ack");
    a_no_ack_berr: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        !(o_dtack_oe && o_berr_oe)) else $error("ack and error together");
    a_grant_taken: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (arb == VBS_ARB_REQ && bg_in && !bbsy && i_ce) |=> (o_bbsy_oe && o_bg_out_n))
        else $error("grant not taken");
    a_chain_blocked: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (state == VBS_RESP && blocked) |-> (o_iackout_n && (o_data_oe || o_berr_oe)))
        else $error("ack chain not held with status");
    a_req_level: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        o_br_oe |-> (o_br_level == REQ_LEVEL && !o_bbsy_oe)) else $error("bad request");
    a_decode_am: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (state == VBS_IDLE && i_ce && next_state == VBS_WAIT && !iack_match) |-> am_hit)
        else $error("answered bad modifier");
    c_read: cover property (@(posedge i_clk) o_dtack_oe && st.write_n && !blocked);
    c_write: cover property (@(posedge i_clk) o_wr_stb);
    c_iack: cover property (@(posedge i_clk) o_dtack_oe && blocked);
    c_own: cover property (@(posedge i_clk) o_bbsy_oe);
endmodule : vbs_backplane

// >>> bench/vbs_master_model.sv
`timescale 1ns/1ps
// Far-side master, plus the slot-one acknowledge chain driver
module vbs_master_model (
    // Clock
    input wire logic i_clk,
    // Pins toward the slave
    output logic o_as_n,
    output logic o_ds0_n,
    output logic o_ds1_n,
    output logic o_write_n,
    output logic o_lword_n,
    output logic o_iack_n,
    output logic o_iackin_n,
    output logic [5:0] o_am,
    output logic [31:1] o_addr,
    output logic [31:0] o_data,
    // Responses
    input wire logic i_dtack_oe,
    input wire logic i_berr_oe
);
    // Idle bus: strobes negated
    initial begin
        {o_as_n, o_ds0_n, o_ds1_n, o_write_n, o_lword_n, o_iack_n, o_iackin_n} = 7'h7F;
        o_am = 6'h3F;
        o_addr = 31'h0;
        o_data = 32'hA5A5A5A5;
    end

    // One strobed cycle; gap delays the strobe to act as a slow master
    task automatic run(input logic [5:0] am, input logic [31:1] adr, input logic [31:0] wd,
            input logic wr, input logic [1:0] width, input logic iack, input logic [1:0] gap,
            output logic got);
        int n;
        @(posedge i_clk);
        o_am <= am;
        o_addr <= adr;
        o_write_n <= ~wr;
        o_lword_n <= (width != 2'h2);
        o_iack_n <= ~iack;
        o_data <= wr ? wd : ~o_data;
        // At least one edge between address and strobe
        repeat (int'(gap) + 1) @(posedge i_clk);
        o_as_n <= 1'b0;
        o_iackin_n <= ~iack;
        @(posedge i_clk);
        o_ds0_n <= 1'b0;
        o_ds1_n <= (width == 2'h0);
        got = 1'b0;
        n = 0;
        while (!got && n < 40) begin
            @(posedge i_clk);
            got = i_dtack_oe | i_berr_oe;
            n++;
        end
        {o_as_n, o_ds0_n, o_ds1_n, o_iack_n, o_iackin_n} <= 5'h1F;
        o_addr <= ~adr;
        o_data <= ~o_data;
        while ((i_dtack_oe | i_berr_oe) && n < 80) begin
            @(posedge i_clk);
            n++;
        end
    endtask : run
endmodule : vbs_master_model

// >>> bench/tb_top.sv
`timescale 1ns/1ps
`include "vbs_defines.svh"
// Master model drives cycles; a monitor matches each answer to its note
module tb_top;
    typedef struct packed {
        logic berr;
        logic rd;
        logic [31:0] val;
        logic [31:1] adr;
    } vbs_note_s;
    logic i_clk, i_reset_n, i_ce, i_bg_in_n, i_bbsy_n, i_bclr_n;
    logic i_want_bus, i_release, i_irq_req, i_as_n, i_ds0_n, i_ds1_n, i_write_n;
    logic i_lword_n, i_iack_n, i_iackin_n, o_data_oe, o_dtack_oe, o_berr_oe, o_bg_out_n;
    logic o_br_oe, o_bbsy_oe, o_iackout_n, o_irq_oe, o_own_bus, o_bclr_seen, o_wr_stb;
    logic [1:0] i_status_width, o_br_level;
    logic [5:0] i_am;
    logic [31:1] i_addr, o_wr_addr;
    logic [31:0] i_status, i_rd_data, i_data, o_data, o_wr_data, wr_seen, val;
    logic [5:0] ams [3] = '{`VBS_AM_A32_DATA, `VBS_AM_A24_DATA, `VBS_AM_A16_DATA};
    logic [30:0] iadr = {28'h0, `VBS_IRQ_LEVEL_DEFAULT};
    vbs_note_s notes[$];
    vbs_note_s note;
    logic [15:0] seed = 16'hD808;
    logic resp_q = 1'b0;
    logic [1:0] width = 2'h2;
    logic passed = 1'b0;
    int fails = 0;
    int checked = 0;
    int cycles = 0;

    vbs_backplane dut (
        .i_clk, .i_reset_n, .i_ce, .i_as_n, .i_ds0_n, .i_ds1_n, .i_write_n, .i_lword_n,
        .i_iack_n, .i_am, .i_addr, .i_data, .o_data, .o_data_oe, .o_dtack_oe, .o_berr_oe,
        .i_bg_in_n, .o_bg_out_n, .i_bbsy_n, .i_bclr_n, .o_br_oe, .o_br_level, .o_bbsy_oe,
        .i_iackin_n, .o_iackout_n, .o_irq_oe, .i_want_bus, .i_release, .o_own_bus,
        .o_bclr_seen, .i_irq_req, .i_status, .i_status_width, .i_rd_data, .o_wr_stb,
        .o_wr_data, .o_wr_addr
    );
    vbs_master_model master (
        .i_clk, .o_as_n(i_as_n), .o_ds0_n(i_ds0_n), .o_ds1_n(i_ds1_n), .o_write_n(i_write_n),
        .o_lword_n(i_lword_n), .o_iack_n(i_iack_n), .o_iackin_n(i_iackin_n), .o_am(i_am),
        .o_addr(i_addr), .o_data(i_data), .i_dtack_oe(o_dtack_oe), .i_berr_oe(o_berr_oe)
    );

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic complete_run();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run

    // Maximal-length 16-bit shift register step
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    // One step of the shift register, spread over 32-bit data
    task automatic rnd();
        seed = lfsr(seed);
        val = {seed, ~seed[7:0], seed[15:8]};
    endtask : rnd

    // Note the expected answer, then run the cycle on the model
    task automatic bus(input logic [5:0] am, input logic [31:1] adr, input logic wr,
            input logic iack, input logic answer, input logic berr);
        logic got;
        if (answer) begin
            notes.push_back('{berr, ~wr, val, adr});
        end
        master.run(am, adr, val, wr, width, iack, seed[1:0], got);
        check("answered", 64'(got), 64'(answer));
    endtask : bus

    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end

    // Hang guard, far above the expected run length
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            complete_run();
        end
    end

    // Monitor: write data is caught on its strobe, answers on their first cycle
    always @(posedge i_clk) begin
        if (o_wr_stb === 1'b1) begin
            wr_seen = o_wr_data;
        end
        if ((o_dtack_oe | o_berr_oe) === 1'b1 && resp_q === 1'b0 && notes.size() > 0) begin
            note = notes.pop_front();
            check("error reply", 64'(o_berr_oe), 64'(note.berr));
            if (!note.berr && note.rd) begin
                check("read data", 64'({o_wr_stb, o_data_oe, o_data}), 64'({2'b01, note.val}));
            end
            if (!note.berr && !note.rd) begin
                check("write", {o_wr_stb, o_wr_addr, wr_seen}, {1'b1, note.adr, note.val});
            end
        end
        resp_q = o_dtack_oe | o_berr_oe;
        if (o_iackout_n === 1'b0) begin
            passed = 1'b1;
        end
    end

    initial begin
        i_reset_n = 1'b0;
        {i_ce, i_bg_in_n, i_bbsy_n, i_bclr_n, i_want_bus, i_release, i_irq_req} = 7'h78;
        {i_status, i_rd_data, i_status_width} = 66'h0;
        repeat (10) @(posedge i_clk);
        i_reset_n <= 1'b1;
        repeat (3) @(posedge i_clk);
        // Write then read through every decoded modifier
        foreach (ams[k]) begin
            rnd();
            bus(ams[k], {`VBS_BASE_DEFAULT, val[14:0]}, 1'b1, 1'b0, 1'b1, 1'b0);
            rnd();
            i_rd_data <= val;
            bus(ams[k], {`VBS_BASE_DEFAULT, val[14:0]}, 1'b0, 1'b0, 1'b1, 1'b0);
        end
        // Foreign modifier or window: no answer at all
        bus(6'h3F, {`VBS_BASE_DEFAULT, val[14:0]}, 1'b1, 1'b0, 1'b0, 1'b0);
        bus(ams[0], {~`VBS_BASE_DEFAULT, val[14:0]}, 1'b1, 1'b0, 1'b0, 1'b0);
        // Interrupt: too narrow a status errs, a fitting one returns and clears
        i_irq_req <= 1'b1;
        @(posedge i_clk);
        i_irq_req <= 1'b0;
        repeat (3) @(posedge i_clk);
        check("request line", 64'(o_irq_oe), 64'h1);
        rnd();
        i_status <= val;
        bus(ams[2], iadr, 1'b0, 1'b1, 1'b1, 1'b1);
        i_status_width <= 2'h2;
        passed = 1'b0;
        bus(ams[2], iadr, 1'b0, 1'b1, 1'b1, 1'b0);
        check("chain held", 64'({passed, o_irq_oe}), 64'h0);
        bus(ams[2], iadr, 1'b0, 1'b1, 1'b0, 1'b0);
        check("chain passed", 64'(passed), 64'h1);
        // Narrow handler widths: D16 refused by a D8 board, D8 served and cleared
        i_irq_req <= 1'b1;
        i_status_width <= 2'h0;
        @(posedge i_clk);
        i_irq_req <= 1'b0;
        width = 2'h1;
        bus(ams[2], iadr, 1'b0, 1'b1, 1'b1, 1'b1);
        width = 2'h0;
        bus(ams[2], iadr, 1'b0, 1'b1, 1'b1, 1'b0);
        width = 2'h2;
        check("narrow cleared", 64'(o_irq_oe), 64'h0);
        // Arbitration: frozen while disabled, request, wait out busy,
        // take the grant despite clear, release, pass it on
        i_ce <= 1'b0;
        i_want_bus <= 1'b1;
        repeat (4) @(posedge i_clk);
        check("frozen", 64'(o_br_oe), 64'h0);
        i_ce <= 1'b1;
        repeat (4) @(posedge i_clk);
        check("request", 64'({o_br_oe, o_br_level}), 64'({1'b1, `VBS_REQ_LEVEL_DEFAULT}));
        i_bg_in_n <= 1'b0;
        i_bclr_n <= 1'b0;
        i_bbsy_n <= 1'b0;
        repeat (5) @(posedge i_clk);
        check("busy wait", 64'({o_bbsy_oe, o_own_bus, o_bg_out_n}), 64'h1);
        i_bbsy_n <= 1'b1;
        repeat (5) @(posedge i_clk);
        check("owner", 64'({o_bbsy_oe, o_own_bus, o_bg_out_n, o_bclr_seen}), 64'hF);
        i_want_bus <= 1'b0;
        i_release <= 1'b1;
        repeat (5) @(posedge i_clk);
        check("grant passed", 64'({o_bbsy_oe, o_bg_out_n}), 64'h0);
        complete_run();
    end
endmodule : tb_top
